// ==== pld_logic_array.sv ====
/*
 * Logic array of the programmable device: global bus, per-block switch
 * matrices, regional foldback buses, cascade chains, the cells, the user
 * signature and the fuse-gated configuration readout.
 * Assumes configuration is held stable by the loader and all pins are
 * synchronous to clk_in.
 */
`timescale 1ns/100ps
module pld_logic_array (
	// Clock and reset
	input wire logic clk_in,
	input wire logic rst_n_in,
	// Pins feeding the global bus
	input wire logic [pld_pkg::NUM_DED-1:0] dedicated_in,
	input wire logic [pld_pkg::NUM_IO-1:0] io_in,
	// Compiled configuration
	input pld_pkg::cell_cfg_t [pld_pkg::NUM_CELLS-1:0] cell_cfg_in,
	input pld_pkg::matrix_sel_t [pld_pkg::NUM_BLOCKS-1:0] matrix_cfg_in,
	input wire logic security_fuse_in,
	// User signature
	input wire logic sig_wr_in,
	input wire logic [pld_pkg::SIG_W-1:0] sig_data_in,
	output logic [pld_pkg::SIG_W-1:0] sig_out,
	// Configuration readout
	input wire logic cfg_rd_in,
	input wire logic [pld_pkg::CELL_IDX_W-1:0] cfg_rd_addr_in,
	output pld_pkg::cell_cfg_t cfg_rd_data_out,
	output logic cfg_rd_valid_out,
	// Cell outputs
	output logic [pld_pkg::NUM_CELLS-1:0] cell_out
);
	import pld_pkg::*;

	cell_res_t [NUM_CELLS-1:0] res;
	logic [NUM_CELLS-1:0] fb;
	logic [NUM_CELLS-1:0] fold_all;
	logic [NUM_CELLS-1:0] casc_in;
	logic [GBUS_W-1:0] gbus;
	logic [NUM_BLOCKS-1:0][MATRIX_W-1:0] block_in;
	logic [NUM_BLOCKS-1:0][MATRIX_W-1:0] matrix_hit;
	logic [NUM_BLOCKS-1:0][REGION_W-1:0] region;
	logic [NUM_BLOCKS-1:0][ARRAY_W-1:0] cell_array;
	cell_cfg_t rd_pick;
	cell_cfg_t next_rd_data;

	// Global bus: buried feedback low, then dedicated pins, then I/O pins
	assign gbus = {io_in, dedicated_in, fb};

	for (genvar b = 0; b < NUM_BLOCKS; b++) begin : g_blk
		for (genvar k = 0; k < MATRIX_W; k++) begin : g_sel
			// Out-of-range selections read as 0 rather than X
			assign matrix_hit[b][k] = matrix_cfg_in[b][k] < GBUS_LIMIT;
			assign block_in[b][k] = matrix_hit[b][k] ? gbus[matrix_cfg_in[b][k]]
				: 1'h0;
		end
		assign region[b] = fold_all[b*CELLS_PER_BLOCK +: CELLS_PER_BLOCK];
		assign cell_array[b] = {region[b], block_in[b]};
	end

	for (genvar c = 0; c < NUM_CELLS; c++) begin : g_cell
		localparam int LOC = c % CELLS_PER_BLOCK;
		localparam int BLK = c / CELLS_PER_BLOCK;
		// Chain heads and cells past the chain length get no cascade
		if (LOC > 0 && LOC < CHAIN_CELLS) begin : g_link
			assign casc_in[c] = res[c-1].cascade_out;
		end else begin : g_head
			assign casc_in[c] = 1'h0;
		end

		logic_cell u_cell (
			.clk_in(clk_in),
			.rst_n_in(rst_n_in),
			.cfg_in(cell_cfg_in[c]),
			.array_in(cell_array[BLK]),
			.cascade_in(casc_in[c]),
			.dedicated_in(dedicated_in),
			.res_out(res[c])
		);

		assign fb[c] = res[c].feedback;
		assign fold_all[c] = res[c].foldback;
		assign cell_out[c] = res[c].out;
	end

	// Readout is blanked once the fuse is set; signature never is
	assign rd_pick = cell_cfg_in[cfg_rd_addr_in];
	assign next_rd_data = security_fuse_in ? cell_cfg_t'('0) : rd_pick;

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			sig_out <= SIG_RST;
		end else if (sig_wr_in) begin
			sig_out <= sig_data_in;
		end
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			cfg_rd_data_out <= cell_cfg_t'('0);
			cfg_rd_valid_out <= 1'h0;
		end else begin
			cfg_rd_valid_out <= cfg_rd_in;
			if (cfg_rd_in) begin
				cfg_rd_data_out <= next_rd_data;
			end
		end
	end

	default clocking @(posedge clk_in); endclocking
	default disable iff (!rst_n_in);

	property p_bus_pins;
		gbus[GBUS_W-1] == io_in[NUM_IO-1] && gbus[NUM_CELLS] == dedicated_in[0];
	endproperty
	a_bus_pins: assert property (p_bus_pins) else $error("Pins missing from bus");
	property p_bus_fb;
		cell_cfg_in[0].fb_from_reg && cell_cfg_in[0].out_from_reg |-> gbus[0] == cell_out[0];
	endproperty
	a_bus_fb: assert property (p_bus_fb) else $error("Feedback missing from bus");
	property p_matrix;
		matrix_cfg_in[1][MATRIX_W-1] == GBUS_IDX_W'(NUM_CELLS)
			|-> cell_array[1][MATRIX_W-1] == dedicated_in[0];
	endproperty
	a_matrix: assert property (p_matrix) else $error("Matrix picked wrong signal");
	property p_region;
		cell_array[2][MATRIX_W+3] == res[2*CELLS_PER_BLOCK+3].foldback;
	endproperty
	a_region: assert property (p_region) else $error("Foldback not on region");
	property p_chain;
		cell_cfg_in[CHAIN_CELLS-1].cascade_en && res[CHAIN_CELLS-2].cascade_out
			|-> res[CHAIN_CELLS-1].cascade_out;
	endproperty
	a_chain: assert property (p_chain) else $error("Cascade link broken");
	property p_chain_end;
		!casc_in[CHAIN_CELLS] && !casc_in[0];
	endproperty
	a_chain_end: assert property (p_chain_end) else $error("Chain runs too long");

	// Staged feedback must reach the bus as the pin sees it
	property p_fb_comb;
		!cell_cfg_in[0].fb_from_reg && !cell_cfg_in[0].out_from_reg |-> gbus[0] == cell_out[0];
	endproperty
	a_fb_comb: assert property (p_fb_comb) else $error("Staged feedback missing");

	property p_bus_io_low;
		gbus[NUM_CELLS+NUM_DED] == io_in[0] && gbus[NUM_CELLS+NUM_DED-1] == dedicated_in[NUM_DED-1];
	endproperty
	a_bus_io_low: assert property (p_bus_io_low) else $error("Pin order on bus wrong");

	property p_matrix_io;
		matrix_cfg_in[0][0] == GBUS_IDX_W'(NUM_CELLS + NUM_DED) |-> cell_array[0][0] == io_in[0];
	endproperty
	a_matrix_io: assert property (p_matrix_io) else $error("Matrix missed a pin");

	// Unused matrix slots must read as a clean low, never X
	property p_matrix_gap;
		!matrix_hit[0][MATRIX_W-1] |-> !cell_array[0][MATRIX_W-1];
	endproperty
	a_matrix_gap: assert property (p_matrix_gap) else $error("Empty slot not low");

	property p_region_last;
		cell_array[NUM_BLOCKS-1][ARRAY_W-1] == res[NUM_CELLS-1].foldback;
	endproperty
	a_region_last: assert property (p_region_last) else $error("Last foldback lost");

	property p_head;
		!casc_in[CELLS_PER_BLOCK] && !casc_in[(NUM_BLOCKS-1)*CELLS_PER_BLOCK];
	endproperty
	a_head: assert property (p_head) else $error("Chain head has cascade");

	property p_casc_pass;
		cell_cfg_in[1].cascade_en && res[0].cascade_out |-> res[1].cascade_out;
	endproperty
	a_casc_pass: assert property (p_casc_pass) else $error("Cascade not passed on");

	property p_sig;
		sig_wr_in ##1 !sig_wr_in [*2] |-> sig_out == $past(sig_data_in, 2);
	endproperty
	a_sig: assert property (p_sig) else $error("Signature not kept");

	// The fuse must never block signature writes
	property p_sig_fuse;
		sig_wr_in && security_fuse_in |=> sig_out == $past(sig_data_in);
	endproperty
	a_sig_fuse: assert property (p_sig_fuse) else $error("Fuse blocked signature");

	property p_sig_hold;
		!sig_wr_in |=> $stable(sig_out);
	endproperty
	a_sig_hold: assert property (p_sig_hold) else $error("Signature moved unasked");

	property p_rd_lock;
		cfg_rd_in && security_fuse_in |=> cfg_rd_valid_out && cfg_rd_data_out == '0;
	endproperty
	a_rd_lock: assert property (p_rd_lock) else $error("Fused contents readable");
	property p_rd_open;
		cfg_rd_in && !security_fuse_in |=> cfg_rd_data_out == $past(rd_pick);
	endproperty
	a_rd_open: assert property (p_rd_open) else $error("Readout data wrong");

	// Valid pulses once per request, even when fused
	property p_rd_valid;
		cfg_rd_in |=> cfg_rd_valid_out;
	endproperty
	a_rd_valid: assert property (p_rd_valid) else $error("Read gave no valid");

	property p_rd_quiet;
		!cfg_rd_in |=> !cfg_rd_valid_out && $stable(cfg_rd_data_out);
	endproperty
	a_rd_quiet: assert property (p_rd_quiet) else $error("Readout moved unasked");

	property p_rd_first;
		cfg_rd_in && !security_fuse_in && cfg_rd_addr_in == '0
			|=> cfg_rd_data_out == $past(cell_cfg_in[0]);
	endproperty
	a_rd_first: assert property (p_rd_first) else $error("First cell read wrong");

	// Main scenarios the bench should reach
	c_fused_read: cover property (security_fuse_in && cfg_rd_in ##1 sig_wr_in);
	c_sig_fused: cover property (sig_wr_in && security_fuse_in);
	c_chain: cover property (cell_cfg_in[CHAIN_CELLS-1].cascade_en && res[CHAIN_CELLS-2].cascade_out);
endmodule : pld_logic_array

// ==== pld_pkg.sv ====
/*
 * Shared constants, enumerations and configuration records for the
 * programmable logic array and its logic cells.
 * Assumes one 40 MHz clock and all pin inputs synchronous to it.
 */
// Summary of operation
// - Five product terms, any global/regional input
// - Term-select mux: sum or control per term
// - All terms ORed give five-term sum
// - Cascade input widens sum to 40 terms
// - XOR operand: term, constant high, constant low
// - Constant XOR operand picks output polarity
// - XOR with register feedback emulates T/JK
// - Cell feedback and all pins drive global bus
// - Switch matrix picks 40 bus signals per block
// - Each cell puts foldback term on regional bus
// - Four cascade chains, up to 40 terms each
// - Dedicated pins selectable as clock or clear
// - 16-bit signature always readable
// - Security fuse blocks configuration readout
// - Rising-edge update; low clock enable ignores edges
// - Latch passes while clock high, holds low
// - Clear: global, term, both, none; preset: term, none
package pld_pkg;
	localparam int NUM_CELLS = 64;
	localparam int PT_PER_CELL = 5;
	localparam int CELLS_PER_BLOCK = 16;
	localparam int NUM_BLOCKS = NUM_CELLS / CELLS_PER_BLOCK;
	localparam int MATRIX_W = 40;
	localparam int REGION_W = CELLS_PER_BLOCK;
	localparam int ARRAY_W = MATRIX_W + REGION_W;
	localparam int CHAIN_CELLS = 8;
	localparam int MAX_CHAIN_PT = CHAIN_CELLS * PT_PER_CELL;
	localparam int NUM_DED = 4;
	localparam int NUM_IO = 68;
	localparam int GBUS_W = NUM_CELLS + NUM_DED + NUM_IO;
	localparam int GBUS_IDX_W = 8;
	localparam logic [GBUS_IDX_W-1:0] GBUS_LIMIT = GBUS_IDX_W'(GBUS_W);
	localparam int SIG_W = 16;
	localparam int CELL_IDX_W = 6;
	localparam int DED_IDX_W = 2;
	localparam int PT_IDX_W = 3;
	// Fixed control role of each term when steered away from the sum
	localparam int PT_XOR = 0;
	localparam int PT_CLK = 1;
	localparam int PT_CLR = 2;
	localparam int PT_PRE = 3;
	localparam int PT_DATA = 4;
	localparam logic Q_RST = 1'h0;
	localparam logic [SIG_W-1:0] SIG_RST = 16'h0000;

	typedef enum logic [1:0] {XOR_LOW, XOR_HIGH, XOR_PT, XOR_REG} xor_sel_t;
	typedef enum logic {CLK_GLOBAL, CLK_PT} clk_src_t;
	typedef enum logic [1:0] {CLR_NONE, CLR_GLOBAL, CLR_PT, CLR_BOTH} clr_sel_t;
	typedef enum logic {PRE_NONE, PRE_PT} pre_sel_t;
	typedef enum logic {STOR_FLOP, STOR_LATCH} stor_t;

	typedef struct packed {
		logic [ARRAY_W-1:0] use_true;
		logic [ARRAY_W-1:0] use_comp;
		logic enable;
		logic to_ctrl;
	} pterm_cfg_t;

	typedef struct packed {
		pterm_cfg_t [PT_PER_CELL-1:0] pt;
		xor_sel_t xor_sel;
		clk_src_t clk_src;
		logic [DED_IDX_W-1:0] clk_pin;
		logic [DED_IDX_W-1:0] clr_pin;
		clr_sel_t clr_sel;
		pre_sel_t pre_sel;
		stor_t stor;
		logic d_from_pt;
		logic cascade_en;
		logic fb_from_reg;
		logic out_from_reg;
		logic [PT_IDX_W-1:0] fold_pt;
	} cell_cfg_t;

	typedef logic [MATRIX_W-1:0][GBUS_IDX_W-1:0] matrix_sel_t;

	typedef struct packed {
		logic out;
		logic feedback;
		logic foldback;
		logic cascade_out;
	} cell_res_t;
endpackage : pld_pkg

// ==== logic_cell.sv ====
/*
 * One logic cell: product terms, term steering, OR/cascade sum, XOR stage
 * and the storage element with its clock, clear and preset selection.
 * Assumes pins and configuration are synchronous to clk_in.
 */
`timescale 1ns/100ps
module logic_cell (
	// Clock and reset
	input wire logic clk_in,
	input wire logic rst_n_in,
	// Configuration
	input pld_pkg::cell_cfg_t cfg_in,
	// Array inputs, cascade and dedicated pins
	input wire logic [pld_pkg::ARRAY_W-1:0] array_in,
	input wire logic cascade_in,
	input wire logic [pld_pkg::NUM_DED-1:0] dedicated_in,
	// Results
	output pld_pkg::cell_res_t res_out
);
	import pld_pkg::*;

	logic [PT_PER_CELL-1:0] pt;
	logic [PT_PER_CELL-1:0] to_sum;
	logic [PT_PER_CELL-1:0] ctrl_pt;
	logic sum, xor_b, xor_out, d, clk_lvl, rise, ce_ok, load;
	logic gclr, clr_act, pre_act, fold_ok, next_q;
	logic q, comb_q, fold, clk_prev;

	for (genvar k = 0; k < PT_PER_CELL; k++) begin : g_pt
		// Disabled terms sit at 0 so they cannot touch sum or controls
		assign pt[k] = cfg_in.pt[k].enable
			&& ((array_in & cfg_in.pt[k].use_true) == cfg_in.pt[k].use_true)
			&& ((~array_in & cfg_in.pt[k].use_comp) == cfg_in.pt[k].use_comp);
		assign to_sum[k] = pt[k] & ~cfg_in.pt[k].to_ctrl;
		assign ctrl_pt[k] = pt[k] & cfg_in.pt[k].to_ctrl;
	end

	assign sum = (|to_sum) | (cascade_in & cfg_in.cascade_en);
	assign xor_b = (cfg_in.xor_sel == XOR_HIGH) ? 1'h1 :
		(cfg_in.xor_sel == XOR_PT) ? ctrl_pt[PT_XOR] :
		(cfg_in.xor_sel == XOR_REG) ? q : 1'h0;
	assign xor_out = sum ^ xor_b;
	assign d = cfg_in.d_from_pt ? ctrl_pt[PT_DATA] : xor_out;

	// Clock: dedicated pin or own term; term 1 becomes enable on pin clocks
	assign clk_lvl = (cfg_in.clk_src == CLK_GLOBAL) ? dedicated_in[cfg_in.clk_pin]
		: ctrl_pt[PT_CLK];
	assign ce_ok = (cfg_in.clk_src != CLK_GLOBAL) || !cfg_in.pt[PT_CLK].to_ctrl
		|| ctrl_pt[PT_CLK];
	assign rise = clk_lvl & ~clk_prev;
	assign load = ce_ok & ((cfg_in.stor == STOR_LATCH) ? clk_lvl : rise);

	assign gclr = dedicated_in[cfg_in.clr_pin];
	assign clr_act = (((cfg_in.clr_sel == CLR_GLOBAL) || (cfg_in.clr_sel == CLR_BOTH)) & gclr)
		| (((cfg_in.clr_sel == CLR_PT) || (cfg_in.clr_sel == CLR_BOTH)) & ctrl_pt[PT_CLR]);
	assign pre_act = (cfg_in.pre_sel == PRE_PT) & ctrl_pt[PT_PRE];
	// Clear wins when both are asserted
	assign next_q = clr_act ? 1'h0 : pre_act ? 1'h1 : load ? d : q;
	assign fold_ok = cfg_in.fold_pt < PT_IDX_W'(PT_PER_CELL);

	// Combinational result and foldback are staged to break bus loops
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			q <= Q_RST;
			comb_q <= Q_RST;
			fold <= Q_RST;
			clk_prev <= Q_RST;
		end else begin
			q <= next_q;
			comb_q <= xor_out;
			fold <= fold_ok & ~pt[cfg_in.fold_pt];
			clk_prev <= clk_lvl;
		end
	end

	assign res_out.out = cfg_in.out_from_reg ? q : comb_q;
	assign res_out.feedback = cfg_in.fb_from_reg ? q : comb_q;
	assign res_out.foldback = fold;
	assign res_out.cascade_out = sum;

	default clocking @(posedge clk_in); endclocking
	default disable iff (!rst_n_in);

	property p_unused;
		(cfg_in.pt[0].enable | cfg_in.pt[1].enable | cfg_in.pt[2].enable
			| cfg_in.pt[3].enable | cfg_in.pt[4].enable) == 1'h0 && !cascade_in |-> !sum;
	endproperty
	a_unused: assert property (p_unused) else $error("Disabled terms drove the sum");
	property p_polarity;
		cfg_in.xor_sel == XOR_HIGH |-> xor_out == !sum;
	endproperty
	a_polarity: assert property (p_polarity) else $error("High operand did not invert");
	property p_ce;
		cfg_in.clk_src == CLK_GLOBAL && cfg_in.pt[PT_CLK].to_ctrl && !pt[PT_CLK]
			&& !clr_act && !pre_act |=> $stable(q);
	endproperty
	a_ce: assert property (p_ce) else $error("Edge taken with enable low");
	property p_latch_hold;
		cfg_in.stor == STOR_LATCH && !clk_lvl && !clr_act && !pre_act |=> $stable(q);
	endproperty
	a_latch_hold: assert property (p_latch_hold) else $error("Latch moved while closed");
	property p_clear;
		clr_act |=> q == 1'h0;
	endproperty
	a_clear: assert property (p_clear) else $error("Clear did not empty cell");
	property p_toggle;
		load && !clr_act && !pre_act && !cfg_in.d_from_pt && cfg_in.xor_sel == XOR_REG
			&& sum |=> q != $past(q);
	endproperty
	a_toggle: assert property (p_toggle) else $error("Toggle mode did not toggle");
	c_toggle: cover property (load && cfg_in.xor_sel == XOR_REG && sum);
	c_latch: cover property (cfg_in.stor == STOR_LATCH && clk_lvl [*3]);
endmodule : logic_cell

// ==== test_pld_logic_array.sv ====
/*
 * Self-checking bench for the logic array: user signature, fuse-gated
 * readout, sum/XOR/cascade paths and a toggle cell with enable and clear.
 * Assumes the design package and the array top module are compiled first.
 */
`timescale 1ns/100ps
module test_pld_logic_array;
	import pld_pkg::*;
	localparam int CW = $bits(cell_cfg_t);
	logic clk_in = 1'b0;
	logic rst_n_in = 1'b0;
	logic [NUM_DED-1:0] dedicated_in = '0;
	logic [NUM_IO-1:0] io_in = '0;
	cell_cfg_t [NUM_CELLS-1:0] cell_cfg = '0;
	matrix_sel_t [NUM_BLOCKS-1:0] matrix_cfg = '1;
	logic security_fuse_in = 1'b0;
	logic sig_wr_in = 1'b0;
	logic [SIG_W-1:0] sig_data_in = '0;
	logic [SIG_W-1:0] sig_out;
	logic cfg_rd_in = 1'b0;
	logic [CELL_IDX_W-1:0] cfg_rd_addr_in = '0;
	cell_cfg_t cfg_rd_data_out;
	logic cfg_rd_valid_out;
	logic [NUM_CELLS-1:0] cell_out;
	logic look = 1'b0;
	logic look_sig = 1'b0;
	logic [CW-1:0] cfg_q[$];
	logic [NUM_CELLS-1:0] val_q[$];
	int fails = 0;
	int checks_done = 0;
	logic q;
	logic prev;
	logic lq;
	logic [NUM_CELLS-1:0] exp_out;
	logic [1:0] c;

	always #12.5 clk_in = ~clk_in;

	pld_logic_array dut (.clk_in, .rst_n_in, .dedicated_in, .io_in,
		.cell_cfg_in(cell_cfg), .matrix_cfg_in(matrix_cfg), .security_fuse_in,
		.sig_wr_in, .sig_data_in, .sig_out, .cfg_rd_in, .cfg_rd_addr_in,
		.cfg_rd_data_out, .cfg_rd_valid_out, .cell_out);

	task automatic check(input logic [CW-1:0] seen, input logic [CW-1:0] exp);
		checks_done++;
		if (seen !== exp) begin
			fails++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : tally_and_finish

	// One cycle; optionally note the value expected after the next edge
	task automatic tick(input logic lk, input logic ls, input logic [NUM_CELLS-1:0] e);
		look = lk;
		look_sig = ls;
		if (lk) val_q.push_back(e);
		@(negedge clk_in);
	endtask : tick

	// Cell 0 output and cell 1 cascade output per mode
	function automatic logic [1:0] comb(input int k, input logic [3:0] io);
		logic s;
		s = (k == 2 ? 1'b0 : io[0]) | (k == 3 ? 1'b0 : ~io[1]);
		return {s, s ^ (k == 1 ? 1'b1 : (k == 2 ? io[0] : 1'b0))};
	endfunction : comb

	// Sampled after the edge so flop updates have landed
	always @(posedge clk_in) begin
		#2;
		if (cfg_rd_valid_out !== 1'b0) begin
			if (cfg_q.size() == 0) cfg_q.push_back('x);
			check(cfg_rd_data_out, cfg_q.pop_front());
		end
		if (look && val_q.size() > 0) begin
			check(look_sig ? CW'(sig_out) : CW'(cell_out), CW'(val_q.pop_front()));
		end
	end

	// Whole run is about 80 cycles; this is generous
	initial begin
		#20000;
		fails++;
		tally_and_finish();
	end

	initial begin
		void'($urandom(32'h81a1_74f7));
		for (int i = 0; i < 4; i++) begin
			matrix_cfg[0][i] = GBUS_IDX_W'(NUM_CELLS + NUM_DED + i);
		end
		matrix_cfg[1][MATRIX_W-1] = GBUS_IDX_W'(NUM_CELLS);
		repeat (2) @(negedge clk_in);
		rst_n_in = 1'b1;
		tick(1'b1, 1'b0, '0);
		tick(1'b1, 1'b1, '0);
		for (int i = 0; i < CW; i++) cell_cfg[5][i] = 1'($urandom());
		for (int k = 0; k < 4; k++) begin
			security_fuse_in = k[1];
			cfg_rd_in = 1'b1;
			cfg_rd_addr_in = k[0] ? 6'h05 : 6'h00;
			cfg_q.push_back(k[1] ? CW'(0) : CW'(cell_cfg[k[0] ? 5 : 0]));
			tick(1'b0, 1'b0, '0);
		end
		cfg_rd_in = 1'b0;
		tick(1'b0, 1'b0, '0);
		$display("test readout done");
		// Random config may have left state behind, so reset again
		cell_cfg[5] = '0;
		rst_n_in = 1'b0;
		tick(1'b0, 1'b0, '0);
		rst_n_in = 1'b1;
		for (int k = 0; k < 3; k++) begin
			security_fuse_in = k[0];
			sig_wr_in = 1'b1;
			sig_data_in = 16'($urandom());
			tick(1'b1, 1'b1, NUM_CELLS'(sig_data_in));
		end
		sig_wr_in = 1'b0;
		tick(1'b1, 1'b1, NUM_CELLS'(sig_data_in));
		$display("test signature done");
		cell_cfg[0].pt[0].use_true[0] = 1'b1;
		cell_cfg[0].pt[0].enable = 1'b1;
		cell_cfg[0].pt[1].use_comp[1] = 1'b1;
		cell_cfg[1].cascade_en = 1'b1;
		for (int k = 0; k < 4; k++) begin
			cell_cfg[0].xor_sel = k == 1 ? XOR_HIGH : (k == 2 ? XOR_PT : XOR_LOW);
			cell_cfg[0].pt[0].to_ctrl = k == 2;
			cell_cfg[0].pt[1].enable = k != 3;
			repeat (6) begin
				io_in = NUM_IO'({$urandom(), $urandom(), $urandom()});
				tick(1'b1, 1'b0, NUM_CELLS'(comb(k, io_in[3:0])));
			end
		end
		$display("test sum and polarity done");
		cell_cfg[2].xor_sel = XOR_REG;
		cell_cfg[2].out_from_reg = 1'b1;
		cell_cfg[2].clr_pin = 2'h1;
		cell_cfg[2].clr_sel = CLR_GLOBAL;
		cell_cfg[2].pt[0].use_true[2] = 1'b1;
		cell_cfg[2].pt[0].enable = 1'b1;
		cell_cfg[2].pt[1].use_true[3] = 1'b1;
		cell_cfg[2].pt[1].enable = 1'b1;
		cell_cfg[2].pt[1].to_ctrl = 1'b1;
		// Cell 3 latches on pin 2; cells 6 and 7 close a cascade link
		cell_cfg[3].stor = STOR_LATCH;
		cell_cfg[3].clk_pin = 2'h2;
		cell_cfg[3].out_from_reg = 1'b1;
		cell_cfg[3].pt[0] = cell_cfg[2].pt[0];
		cell_cfg[6].pt[0].enable = 1'b1;
		cell_cfg[7].cascade_en = 1'b1;
		lq = 1'b0;
		q = 1'b0;
		prev = 1'b0;
		repeat (40) begin
			c = 2'($urandom());
			dedicated_in = 4'($urandom());
			dedicated_in[1] = ($urandom() % 8) == 0;
			io_in[3:2] = c;
			if (dedicated_in[1]) q = 1'b0;
			else if (dedicated_in[0] && !prev && c[1]) q = q ^ c[0];
			if (dedicated_in[2]) lq = c[0];
			prev = dedicated_in[0];
			exp_out = NUM_CELLS'({2'h3, 2'h0, lq, q, comb(3, io_in[3:0])});
			tick(1'b1, 1'b0, exp_out);
		end
		tick(1'b0, 1'b0, '0);
		$display("test toggle cell done");
		check(CW'(cfg_q.size() + val_q.size()), CW'(0));
		tally_and_finish();
	end
endmodule : test_pld_logic_array
